// file: core/bscm_defs.svh
// Purpose: Constants of the bridge sensor correction math block.
// Assumes: Word addresses index a 20-word nonvolatile image.
// Notes: Arithmetic constants are 64-bit signed to match the datapath.
`ifndef BSCM_DEFS_SVH
`define BSCM_DEFS_SVH
// Nonvolatile word addresses.
`define BSCM_W_ID0 5'h00
`define BSCM_W_CFG 5'h01
`define BSCM_W_GAIN_B 5'h02
`define BSCM_W_OFF_B 5'h03
`define BSCM_W_TCG 5'h04
`define BSCM_W_TCO 5'h05
`define BSCM_W_GAIN_TEMP_SECOND_ORDER 5'h06
`define BSCM_W_OFFSET_TEMP_SECOND_ORDER 5'h07
`define BSCM_W_SOT_BR 5'h08
`define BSCM_W_LOW_CAL_TEMPERATURE_REF 5'h09
`define BSCM_W_GAIN_T 5'h0A
`define BSCM_W_OFF_T 5'h0B
`define BSCM_W_TEMPERATURE_SECOND_ORDER 5'h0C
`define BSCM_W_ID1 5'h0E
`define BSCM_W_B_CFG 5'h0F
`define BSCM_W_SIG 5'h12
`define BSCM_W_ID2 5'h13
`define BSCM_W_LAST 5'h13
// Bit positions in the configuration and gain words.
`define BSCM_B_CURVE 9
`define BSCM_B_TCG_NEG 10
`define BSCM_B_TCO_NEG 11
`define BSCM_B_STCG_NEG 12
`define BSCM_B_STCO_NEG 13
`define BSCM_B_SBR_NEG 14
`define BSCM_B_ST_NEG 15
`define BSCM_B_GAIN_TIMES_EIGHT 15
`define BSCM_B_ADC_MSB 3
// Fixed-point scaling.
`define BSCM_UNITY_SH 13
`define BSCM_G8_SH 3
`define BSCM_TC_SH 15
`define BSCM_SOT_SH 24
`define BSCM_ADC_SH 10
`define BSCM_ONE_Q 64'sh8000
`define BSCM_UNS_OFS 64'sh2000
`define BSCM_OUT_MAX 64'sh3FFF
// Signature generator.
`define BSCM_SIG_SEED 16'hFFFF
`define BSCM_SIG_POLY 16'h1021
`endif

// file: core/bscm_pkg.sv
// Purpose: Types shared by the correction math block.
// Assumes: Constants come from bscm_defs.svh.
// Notes: Raw bridge is 14-bit signed, sign-extended to 16 bits.
package bscm_pkg;
   typedef enum logic [2:0]
   {
      BSCM_IDLE = 3'b000,
      BSCM_WALK = 3'b001,
      BSCM_ZCALC = 3'b010,
      BSCM_FCALC = 3'b011,
      BSCM_SIGWR = 3'b100
   } bscm_state_t;
   typedef struct packed {
      logic [4:0] addr;
      logic [15:0] data;
   } bscm_nvw_t;
   typedef struct packed {
      logic [15:0] bridge;
      logic [13:0] temp;
   } bscm_raw_t;
   typedef struct packed {
      logic [13:0] bridge;
      logic [13:0] temp;
   } bscm_res_t;
   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] gain_b;
      logic [15:0] off_b;
      logic [15:0] tcg;
      logic [15:0] tco;
      logic [15:0] gain_temp_second_order;
      logic [15:0] offset_temp_second_order;
      logic [15:0] sot_br;
      logic [15:0] low_cal_temperature_ref;
      logic [15:0] gain_t;
      logic [15:0] off_t;
      logic [15:0] temperature_second_order;
      logic [15:0] b_cfg;
   } bscm_coef_t;
endpackage

// file: core/bscm_nvmem.sv
// Purpose: Nonvolatile word image with one write and one read port.
// Assumes: Read data are registered; a read sees the old word on a write.
// Notes: Unmapped read addresses return zero.
`timescale 1ns/100ps
module bscm_nvmem #(
   parameter int DW = 16,
   parameter int AW = 5,
   parameter int DEPTH = 20
)
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Write port.
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port.
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);
   logic [DW-1:0] mem_reg [DEPTH];
   logic [DW-1:0] mem_next [DEPTH];
   logic [DW-1:0] rdata_next;

   // Next image and read word.
   always_comb
   begin
      mem_next = mem_reg;
      rdata_next = '0;
      if (we && (32'(waddr) < DEPTH))
      begin
         mem_next[waddr] = wdata;
      end
      if (32'(raddr) < DEPTH)
      begin
         rdata_next = mem_reg[raddr];
      end
   end

   // Storage; cleared so a fresh simulation carries no unknowns.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_reg[i] <= '0;
         end
         rdata <= '0;
      end
      else
      begin
         mem_reg <= mem_next;
         rdata <= rdata_next;
      end
   end
endmodule // bscm_nvmem

// file: core/bscm_core.sv
// Purpose: Bridge and temperature correction math with its word image.
// Assumes: Requests come from logic on core_clk, one cycle pulses.
// Notes: Each conversion reloads every coefficient from the image.
`timescale 1ns/100ps
`include "bscm_defs.svh"
module bscm_core
(
   // Clock and reset.
   input wire logic core_clk,
   input wire logic nrst,
   // Conversion input.
   input wire logic conv_done,
   input wire bscm_pkg::bscm_raw_t raw_in,
   // Image access and commands.
   input wire logic nv_wr,
   input wire bscm_pkg::bscm_nvw_t nv_wr_req,
   input wire logic nv_rd,
   input wire logic [4:0] nv_rd_addr,
   input wire logic normal_operation_start_cmd,
   output logic nv_rd_valid,
   output logic [15:0] nv_rdata,
   // Status and results.
   output logic busy,
   output logic nv_dirty,
   output logic res_valid,
   output bscm_pkg::bscm_res_t res
);
   import bscm_pkg::*;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   function automatic logic signed [63:0] smag(input logic [15:0] m, input logic neg);
      logic signed [63:0] v;
      v = $signed({48'h0, m});
      return neg ? -v : v;
   endfunction

   function automatic logic signed [63:0] sx(input logic [15:0] m);
      return $signed({{48{m[15]}}, m});
   endfunction

   function automatic logic signed [63:0] geff(input logic [15:0] g);
      logic signed [63:0] v;
      v = $signed({49'h0, g[14:0]});
      if (g[`BSCM_B_GAIN_TIMES_EIGHT])
      begin
         v = v <<< `BSCM_G8_SH;
      end
      return v;
   endfunction

   function automatic logic [13:0] sat14(input logic signed [63:0] v);
      logic [13:0] r;
      r = v[13:0];
      if (v < 0)
      begin
         r = '0;
      end
      else if (v > `BSCM_OUT_MAX)
      begin
         r = 14'(`BSCM_OUT_MAX);
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // Control state
   // ----------------------------------------------------------------
   bscm_state_t state_reg, state_next;
   logic [4:0] addr_reg, addr_next;
   logic cap_vld_reg, cap_vld_next;
   logic [4:0] cap_addr_reg, cap_addr_next;
   bscm_coef_t coef_reg, coef_next;
   bscm_raw_t raw_reg, raw_next;
   logic [15:0] sig_reg, sig_next;
   logic job_reg, job_next;
   logic dirty_reg, dirty_next;
   logic rdv_reg, rdv_next;
   logic mem_we;
   logic [4:0] mem_waddr, mem_raddr;
   logic [15:0] mem_wdata, mem_rdata;
   logic idle;

   assign idle = (state_reg == BSCM_IDLE);
   assign busy = !idle;
   assign nv_dirty = dirty_reg;
   assign nv_rd_valid = rdv_reg;
   assign nv_rdata = mem_rdata;

   // Request arbitration, coefficient walk and signature generation.
   // Requests that arrive while busy are dropped, so callers watch busy.
   always_comb
   begin
      state_next = state_reg;
      addr_next = addr_reg;
      cap_vld_next = 1'b0;
      cap_addr_next = cap_addr_reg;
      coef_next = coef_reg;
      raw_next = raw_reg;
      sig_next = sig_reg;
      job_next = job_reg;
      dirty_next = dirty_reg;
      rdv_next = 1'b0;
      mem_we = 1'b0;
      mem_waddr = nv_wr_req.addr;
      mem_wdata = nv_wr_req.data;
      mem_raddr = addr_reg;
      case (state_reg)
         BSCM_IDLE:
         begin
            mem_raddr = nv_rd_addr;
            addr_next = '0;
            sig_next = `BSCM_SIG_SEED;
            if (nv_wr)
            begin
               mem_we = 1'b1;
               dirty_next = 1'b1;
            end
            else if (normal_operation_start_cmd)
            begin
               job_next = 1'b1;
               state_next = BSCM_WALK;
            end
            else if (conv_done)
            begin
               job_next = 1'b0;
               raw_next = raw_in;
               state_next = BSCM_WALK;
            end
            else if (nv_rd)
            begin
               rdv_next = 1'b1;
            end
         end
         BSCM_WALK:
         begin
            if (addr_reg <= `BSCM_W_LAST)
            begin
               cap_vld_next = 1'b1;
               cap_addr_next = addr_reg;
               addr_next = 5'(addr_reg + 5'h01);
            end
            if (cap_vld_reg)
            begin
               case (cap_addr_reg)
                  `BSCM_W_CFG: coef_next.cfg = mem_rdata;
                  `BSCM_W_GAIN_B: coef_next.gain_b = mem_rdata;
                  `BSCM_W_OFF_B: coef_next.off_b = mem_rdata;
                  `BSCM_W_TCG: coef_next.tcg = mem_rdata;
                  `BSCM_W_TCO: coef_next.tco = mem_rdata;
                  `BSCM_W_GAIN_TEMP_SECOND_ORDER: coef_next.gain_temp_second_order = mem_rdata;
                  `BSCM_W_OFFSET_TEMP_SECOND_ORDER: coef_next.offset_temp_second_order = mem_rdata;
                  `BSCM_W_SOT_BR: coef_next.sot_br = mem_rdata;
                  `BSCM_W_LOW_CAL_TEMPERATURE_REF: coef_next.low_cal_temperature_ref = mem_rdata;
                  `BSCM_W_GAIN_T: coef_next.gain_t = mem_rdata;
                  `BSCM_W_OFF_T: coef_next.off_t = mem_rdata;
                  `BSCM_W_TEMPERATURE_SECOND_ORDER: coef_next.temperature_second_order = mem_rdata;
                  `BSCM_W_B_CFG: coef_next.b_cfg = mem_rdata;
                  default: coef_next = coef_reg;
               endcase
               // The stored signature word is kept out of its own sum.
               if (cap_addr_reg != `BSCM_W_SIG)
               begin
                  sig_next = {sig_reg[14:0], 1'b0} ^ mem_rdata
                     ^ (sig_reg[15] ? `BSCM_SIG_POLY : 16'h0000);
               end
               if (cap_addr_reg == `BSCM_W_LAST)
               begin
                  state_next = job_reg ? BSCM_SIGWR : BSCM_ZCALC;
               end
            end
         end
         BSCM_ZCALC: state_next = BSCM_FCALC;
         BSCM_FCALC: state_next = BSCM_IDLE;
         BSCM_SIGWR:
         begin
            mem_we = 1'b1;
            mem_waddr = `BSCM_W_SIG;
            mem_wdata = sig_reg;
            dirty_next = 1'b0;
            state_next = BSCM_IDLE;
         end
         default: state_next = BSCM_IDLE;
      endcase
   end

   // Control registers.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state_reg <= BSCM_IDLE;
         addr_reg <= '0;
         cap_vld_reg <= 1'b0;
         cap_addr_reg <= '0;
         coef_reg <= '0;
         raw_reg <= '0;
         sig_reg <= `BSCM_SIG_SEED;
         job_reg <= 1'b0;
         dirty_reg <= 1'b0;
         rdv_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         addr_reg <= addr_next;
         cap_vld_reg <= cap_vld_next;
         cap_addr_reg <= cap_addr_next;
         coef_reg <= coef_next;
         raw_reg <= raw_next;
         sig_reg <= sig_next;
         job_reg <= job_next;
         dirty_reg <= dirty_next;
         rdv_reg <= rdv_next;
      end
   end

   bscm_nvmem #(.DW(16), .AW(5), .DEPTH(20)) u_mem (
      .core_clk(core_clk),
      .nrst(nrst),
      .we(mem_we),
      .waddr(mem_waddr),
      .wdata(mem_wdata),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // ----------------------------------------------------------------
   // Datapath
   // ----------------------------------------------------------------
   logic signed [63:0] dt, tco_t, tcg_t, adc, sum, zb_calc, zt_calc;
   logic signed [63:0] b_calc, t_calc, zb_abs;
   logic signed [63:0] zb_reg, zb_next, zt_reg, zt_next;
   bscm_res_t res_next;
   logic res_vld_next;
   logic curve;
   logic [15:0] cf;

   assign cf = coef_reg.cfg;
   assign curve = cf[`BSCM_B_CURVE];
   assign dt = $signed({50'h0, raw_reg.temp}) - $signed({48'h0, coef_reg.low_cal_temperature_ref});
   assign tco_t = (dt * (((smag(coef_reg.offset_temp_second_order, cf[`BSCM_B_STCO_NEG]) * dt)
      >>> `BSCM_TC_SH) + smag(coef_reg.tco, cf[`BSCM_B_TCO_NEG]))) >>> `BSCM_TC_SH;
   assign tcg_t = (dt * (((smag(coef_reg.gain_temp_second_order, cf[`BSCM_B_STCG_NEG]) * dt)
      >>> `BSCM_TC_SH) + smag(coef_reg.tcg, cf[`BSCM_B_TCG_NEG]))) >>> `BSCM_TC_SH;
   assign adc = $signed({60'h0, coef_reg.b_cfg[`BSCM_B_ADC_MSB:0]}) <<< `BSCM_ADC_SH;
   assign sum = sx(raw_reg.bridge) + sx(coef_reg.off_b) - adc + tco_t;
   // Gain, temperature gain and sum; gain format.
   // Unsigned constant only in parabolic mode.
   assign zb_calc = ((((geff(coef_reg.gain_b) * sum) >>> `BSCM_UNITY_SH)
      * (`BSCM_ONE_Q + tcg_t)) >>> `BSCM_TC_SH)
      + (curve ? 64'sh0 : `BSCM_UNS_OFS);
   assign zt_calc = (geff(coef_reg.gain_t) * ($signed({50'h0, raw_reg.temp})
      + sx(coef_reg.off_t))) >>> `BSCM_UNITY_SH;
   // S-shape uses Z times its magnitude so the curve stays odd about zero.
   assign zb_abs = (zb_reg < 0) ? -zb_reg : zb_reg;
   assign b_calc = zb_reg + ((smag(coef_reg.sot_br, cf[`BSCM_B_SBR_NEG]) * zb_reg
      * (curve ? zb_abs : zb_reg)) >>> `BSCM_SOT_SH);
   assign t_calc = zt_reg + ((smag(coef_reg.temperature_second_order, cf[`BSCM_B_ST_NEG]) * zt_reg
      * zt_reg) >>> `BSCM_SOT_SH);

   // Two math stages keep each multiplier chain to one cycle.
   always_comb
   begin
      zb_next = zb_reg;
      zt_next = zt_reg;
      res_next = res;
      res_vld_next = 1'b0;
      if (state_reg == BSCM_ZCALC)
      begin
         zb_next = zb_calc;
         zt_next = zt_calc;
      end
      if (state_reg == BSCM_FCALC)
      begin
         res_next.bridge = sat14(b_calc);
         res_next.temp = sat14(t_calc);
         res_vld_next = 1'b1;
      end
   end

   // Math registers and results.
   always_ff @(posedge core_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         zb_reg <= '0;
         zt_reg <= '0;
         res <= '0;
         res_valid <= 1'b0;
      end
      else
      begin
         zb_reg <= zb_next;
         zt_reg <= zt_next;
         res <= res_next;
         res_valid <= res_vld_next;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   conv_latency_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (idle && !nv_wr && !normal_operation_start_cmd && conv_done) |-> ##24 res_valid)
      else $error("result not 24 cycles after conversion");
   busy_walk_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (idle && !nv_wr && conv_done) |=> busy [*8])
      else $error("busy dropped during walk");
   res_pulse_a: assert property (@(posedge core_clk) disable iff (!nrst)
      res_valid |=> !res_valid)
      else $error("result valid longer than one cycle");
   para_ofs_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == BSCM_ZCALC && !curve && coef_reg.gain_b == 16'h0000)
      |=> zb_reg == `BSCM_UNS_OFS)
      else $error("parabolic constant missing");
   sshape_ofs_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == BSCM_ZCALC && curve && coef_reg.gain_b == 16'h0000)
      |=> zb_reg == 64'sh0)
      else $error("S-shaped constant added");
   unity_gain_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == BSCM_ZCALC && curve && coef_reg.gain_b == 16'h2000
       && coef_reg.tcg == 16'h0000 && coef_reg.gain_temp_second_order == 16'h0000
       && coef_reg.tco == 16'h0000 && coef_reg.offset_temp_second_order == 16'h0000)
      |=> zb_reg == sx(raw_reg.bridge) + sx(coef_reg.off_b)
         - $signed({60'h0, coef_reg.b_cfg[`BSCM_B_ADC_MSB:0]}) * 64'sd16384 / 64'sd16)
      else $error("unity gain bridge mismatch");
   temp_zero_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (state_reg == BSCM_ZCALC && coef_reg.gain_t == 16'h0000)
      |=> ##1 (res_valid && res.temp == 14'h0000))
      else $error("zero temperature gain not zero");
   sig_store_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (idle && !nv_wr && normal_operation_start_cmd)
      |-> ##22 (mem_we && mem_waddr == `BSCM_W_SIG) ##1 !nv_dirty)
      else $error("signature not stored after start command");
   dirty_set_a: assert property (@(posedge core_clk) disable iff (!nrst)
      (idle && nv_wr) |=> (nv_dirty && busy == 1'b0))
      else $error("image write not flagged");
endmodule // bscm_core

// file: verif/bscm_cal_master.sv
// Purpose: Calibration master model that drives requests into the correction block.
// Assumes: Requests launch on the falling edge of core_clk and last one cycle.
// Notes: A wait that runs out raises hung; released lines show inverted data.
`timescale 1ns/100ps
module bscm_cal_master
(
   // Clock and status.
   input wire logic core_clk,
   input wire logic busy,
   input wire logic nv_rd_valid,
   input wire logic [15:0] nv_rdata,
   // Requests.
   output bscm_pkg::bscm_raw_t raw_in,
   output logic conv_done,
   output logic nv_wr,
   output bscm_pkg::bscm_nvw_t nv_wr_req,
   output logic nv_rd,
   output logic [4:0] nv_rd_addr,
   output logic normal_operation_start_cmd,
   output logic hung
);
   import bscm_pkg::*;
   // Uncalibrated temperature defaults; the values are arbitrary.
   localparam logic [15:0] TDEF [0:3] = '{16'h2000, 16'h0000, 16'h0000, 16'h0000};
   logic changed;
   logic [7:0] wafer_y;

   // Idle request lines from time zero.
   initial
   begin
      raw_in = '0;
      conv_done = 1'b0;
      nv_wr = 1'b0;
      nv_wr_req = '0;
      nv_rd = 1'b0;
      nv_rd_addr = '0;
      normal_operation_start_cmd = 1'b0;
      hung = 1'b0;
      changed = 1'b0;
      wafer_y = '0;
   end

   // Requests made while busy are dropped, so wait for idle, but not forever.
   task automatic launch();
      int n;
      n = 0;
      @(negedge core_clk);
      while (busy !== 1'b0 && n < 200)
      begin
         n++;
         @(negedge core_clk);
      end
      if (n >= 200)
         hung = 1'b1;
   endtask

   task automatic write_word(logic [4:0] a, logic [15:0] d);
      launch();
      nv_wr_req = {a, d};
      nv_wr = 1'b1;
      changed = 1'b1;
      @(negedge core_clk);
      nv_wr = 1'b0;
      nv_wr_req = ~nv_wr_req;
   endtask

   task automatic read_word(logic [4:0] a, output logic [15:0] d, output logic v);
      launch();
      nv_rd_addr = a;
      nv_rd = 1'b1;
      @(posedge core_clk);
      @(negedge core_clk);
      // The answer stands only in the cycle after the taking edge, so take it now.
      v = nv_rd_valid;
      d = nv_rdata;
      nv_rd = 1'b0;
      nv_rd_addr = ~nv_rd_addr;
   endtask

   task automatic start_normal();
      launch();
      normal_operation_start_cmd = 1'b1;
      changed = 1'b0;
      @(negedge core_clk);
      normal_operation_start_cmd = 1'b0;
   endtask

   task automatic write_id(logic [47:0] id);
      logic [15:0] d;
      logic v;
      read_word(5'h0E, d, v);
      wafer_y = d[7:0];
      write_word(5'h00, id[15:0]);
      write_word(5'h0E, id[31:16]);
      write_word(5'h13, id[47:32]);
   endtask

   task automatic load_image(logic [15:0] img [0:19]);
      for (int i = 0; i < 4; i++)
         write_word(5'(10 + i), TDEF[i]);
      for (int i = 1; i < 13; i++)
         write_word(5'(i), img[i]);
      write_word(5'h0F, img[15]);
   endtask

   task automatic convert(logic [15:0] br, logic [13:0] tp);
      if (changed)
         start_normal();
      launch();
      raw_in = {br, tp};
      conv_done = 1'b1;
      @(negedge core_clk);
      conv_done = 1'b0;
      raw_in = ~raw_in;
   endtask
endmodule // bscm_cal_master

// file: verif/bridge_sensor_correction_math_test.sv
// Purpose: Self-checking bench for the correction math block.
// Assumes: Falling-edge stimulus through the calibration master model.
// Notes: Coefficients are picked so the fixed-point results are exact.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module bridge_sensor_correction_math_test;
   import bscm_pkg::*;
   logic core_clk;
   logic nrst;
   logic conv_done, nv_wr, nv_rd, normal_operation_start_cmd, hung;
   logic nv_rd_valid, busy, nv_dirty, res_valid, ok;
   logic [4:0] nv_rd_addr;
   logic [15:0] nv_rdata, rd;
   bscm_raw_t raw_in;
   bscm_nvw_t nv_wr_req;
   bscm_res_t res;
   int bad_count, comparisons;
   logic [15:0] img [0:19];
   logic [47:0] id;
   localparam logic [4:0] IDW [0:2] = '{5'h00, 5'h0E, 5'h13};
   localparam int SADR [0:5] = '{4, 5, 6, 7, 8, 12};
   localparam logic [15:0] DRC [0:3] = '{16'h0000, 16'h2800, 16'h0000, 16'h0400};
   localparam logic [15:0] DRR [0:3] = '{16'h07FC, 16'h0A04, 16'h09FC, 16'h09FC};
   localparam logic [13:0] DRT [0:3] = '{14'h1200, 14'h1200, 14'h0E00, 14'h0E00};
   // Columns: config, bridge gain, raw bridge, temp gain, temp offset, temp sot, raw temp.
   localparam logic [15:0] TAB [0:6][0:6] = '{
      '{16'h0000, 16'h2000, 16'hF000, 16'h2000, 16'hF000, 16'h0100, 16'h2000},
      '{16'hC000, 16'h2000, 16'hF000, 16'h2000, 16'hF000, 16'h0100, 16'h2000},
      '{16'h0200, 16'h2000, 16'h1000, 16'h4000, 16'h0000, 16'h0000, 16'h0BB8},
      '{16'h4200, 16'h2000, 16'h1000, 16'h8400, 16'h0000, 16'h0000, 16'h1388},
      '{16'h0200, 16'h8400, 16'h1000, 16'h2000, 16'h1000, 16'h0000, 16'h3E80},
      '{16'h0000, 16'h4000, 16'h0800, 16'h2000, 16'h0000, 16'h0000, 16'h0100},
      '{16'h0200, 16'h2000, 16'hF000, 16'h2000, 16'h0000, 16'h0000, 16'h0000}};

   bscm_core i_bscm_core (.core_clk(core_clk), .nrst(nrst), .conv_done(conv_done),
      .raw_in(raw_in), .nv_wr(nv_wr), .nv_wr_req(nv_wr_req), .nv_rd(nv_rd),
      .nv_rd_addr(nv_rd_addr), .normal_operation_start_cmd(normal_operation_start_cmd),
      .nv_rd_valid(nv_rd_valid), .nv_rdata(nv_rdata), .busy(busy), .nv_dirty(nv_dirty),
      .res_valid(res_valid), .res(res));
   bscm_cal_master i_bscm_cal_master (.core_clk(core_clk), .busy(busy),
      .nv_rd_valid(nv_rd_valid), .nv_rdata(nv_rdata), .raw_in(raw_in),
      .conv_done(conv_done), .nv_wr(nv_wr), .nv_wr_req(nv_wr_req), .nv_rd(nv_rd),
      .nv_rd_addr(nv_rd_addr), .normal_operation_start_cmd(normal_operation_start_cmd),
      .hung(hung));

   // 40 MHz clock.
   initial
   begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end

   function automatic longint gval(logic [15:0] w);
      return w[15] ? longint'(w[14:0]) <<< 3 : longint'(w[14:0]);
   endfunction

   function automatic logic [13:0] sat(longint v);
      return (v < 0) ? 14'h0000 : ((v > 16383) ? 14'h3FFF : 14'(v));
   endfunction

   // Reference arithmetic in plain integers over the image copy.
   function automatic logic [27:0] model(logic [15:0] br, logic [13:0] tp);
      longint s [0:5];
      longint dt, gf, ofs, z, b, zt, t;
      for (int i = 0; i < 6; i++)
         s[i] = img[1][10 + i] ? -longint'(img[SADR[i]]) : longint'(img[SADR[i]]);
      dt = longint'(tp) - longint'(img[9]);
      gf = 32768 + ((dt * (((s[2] * dt) >>> 15) + s[0])) >>> 15);
      ofs = longint'($signed(br)) + longint'($signed(img[3])) - longint'(img[15][3:0]) * 1024;
      ofs = ofs + ((dt * (((s[3] * dt) >>> 15) + s[1])) >>> 15);
      z = (((gval(img[2]) * gf) >>> 15) * ofs) >>> 13;
      if (img[1][9])
         b = z + ((s[4] * z * ((z < 0) ? -z : z)) >>> 24);
      else
         b = z + 8192 + ((s[4] * (z + 8192) * (z + 8192)) >>> 24);
      zt = (gval(img[10]) * (longint'(tp) + longint'($signed(img[11])))) >>> 13;
      t = zt + ((s[5] * zt * zt) >>> 24);
      return {sat(b), sat(t)};
   endfunction

   task automatic neutral();
      foreach (img[i])
         img[i] = 16'h0000;
      img[2] = 16'h2000;
      img[10] = 16'h2000;
   endtask

   // Load, convert, then expect the result to stand just after the 24th edge past the request.
   task automatic run_conv(logic [15:0] br, logic [13:0] tp);
      logic [27:0] exp;
      exp = model(br, tp);
      i_bscm_cal_master.load_image(img);
      i_bscm_cal_master.convert(br, tp);
      repeat (22) @(posedge core_clk);
      #1;
      `CHK(res_valid, 1'b0)
      @(posedge core_clk);
      #1;
      `CHK(res_valid, 1'b1)
      `CHK(res, exp)
   endtask

   task automatic give_verdict();
      $display("comparisons=%0d bad_count=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // A hung handshake ends the run.
   always @(posedge hung)
   begin
      bad_count++;
      give_verdict();
   end

   initial
   begin
      bad_count = 0;
      comparisons = 0;
      nrst = 1'b0;
      void'($urandom(15836));
      repeat (12) @(posedge core_clk);
      @(negedge core_clk);
      nrst = 1'b1;
      `CHK({busy, nv_dirty, res_valid, res}, 31'h0)
      // Identifier words: cleared, written, read back; unmapped word reads zero.
      id = {16'($urandom), 32'($urandom)};
      for (int i = 0; i < 3; i++)
      begin
         i_bscm_cal_master.read_word(IDW[i], rd, ok);
         `CHK({ok, rd}, 17'h10000)
      end
      i_bscm_cal_master.write_id(id);
      for (int i = 0; i < 3; i++)
      begin
         i_bscm_cal_master.read_word(IDW[i], rd, ok);
         `CHK({ok, rd}, {1'b1, id[16 * i +: 16]})
      end
      i_bscm_cal_master.read_word(5'h1F, rd, ok);
      `CHK({ok, rd}, 17'h10000)
      `CHK(nv_dirty, 1'b1)
      i_bscm_cal_master.start_normal();
      repeat (21) @(posedge core_clk);
      #1;
      `CHK({busy, nv_dirty}, 2'b11)
      @(posedge core_clk);
      #1;
      `CHK({busy, nv_dirty}, 2'b00)
      $display("test ids done");
      // Every converter offset code.
      neutral();
      img[3] = 16'h1000;
      for (int c = 0; c < 16; c++)
      begin
         img[15] = 16'(c);
         run_conv(16'(c * 64), 14'h0100);
      end
      $display("test offset codes done");
      // Curve shapes, signs, gain times eight, temperature path, saturation.
      neutral();
      img[8] = 16'h0100;
      for (int i = 0; i < 7; i++)
      begin
         img[1] = TAB[i][0];
         img[2] = TAB[i][1];
         img[10] = TAB[i][3];
         img[11] = TAB[i][4];
         img[12] = TAB[i][5];
         run_conv(TAB[i][2], TAB[i][6][13:0]);
      end
      $display("test curves done");
      // Temperature drift terms above and below the low calibration point.
      neutral();
      img[3] = 16'hFC00;
      img[4] = 16'h4000;
      img[5] = 16'h4000;
      img[7] = 16'h4000;
      img[9] = 16'h1000;
      for (int i = 0; i < 4; i++)
      begin
         img[1] = DRC[i];
         run_conv(DRR[i], DRT[i]);
      end
      $display("test drift done");
      // Seven random calibration points.
      neutral();
      for (int i = 0; i < 7; i++)
      begin
         // The first two points zero the bridge gain to reach the constant-only paths; the second also zeroes the temperature gain.
         img[1] = (i == 1) ? 16'h0200 : 16'h0000;
         img[2] = (i < 2) ? 16'h0000 : 16'h2000;
         img[10] = (i == 1) ? 16'h0000 : 16'h2000;
         img[3] = 16'($urandom_range(8191)) - 16'h1000;
         img[11] = 16'($urandom_range(4095));
         img[15] = 16'($urandom_range(15));
         run_conv(16'($urandom_range(16383)) - 16'h2000, 14'($urandom_range(16383)));
      end
      $display("test random done");
      give_verdict();
   end
endmodule // bridge_sensor_correction_math_test
